// ---- inc/ppm_pkg.sv ----
package ppm_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  // Index of each register; byte address is four times it
  localparam logic [31:0] PPM_P1_DATA_IDX = 32'hfffff402;
  localparam logic [31:0] PPM_P2_DATA_IDX = 32'hfffff404;
  localparam logic [31:0] PPM_P1_DIR_IDX = 32'hfffff422;
  localparam logic [31:0] PPM_P2_DIR_IDX = 32'hfffff424;
  localparam logic [31:0] PPM_P1_MODE_IDX = 32'hfffff442;
  localparam logic [31:0] PPM_P2_MODE_IDX = 32'hfffff444;
  localparam logic [31:0] PPM_P1_FUNC_IDX = 32'hfffff462;
  localparam logic [31:0] PPM_P2_FUNC_IDX = 32'hfffff464;

  // ----------------------------------------
  // Reset values and bit masks
  // ----------------------------------------
  localparam logic [7:0] PPM_DIR_RST = 8'hff;
  localparam logic [7:0] PPM_MODE_RST = 8'h00;
  localparam logic [7:0] PPM_FUNC_RST = 8'h00;
  localparam logic [7:0] PPM_DATA_RST = 8'h00;
  // Port 1 upper pair of direction bits always read one
  localparam logic [7:0] PPM_P1_DIR_ONES = 8'hc0;
  localparam logic [7:0] PPM_P1_PIN_MASK = 8'h3f;
  // Only timer pins 0 and 3 own a function selector
  localparam logic [7:0] PPM_P1_FUNC_MASK = 8'h09;
  // Port 2 selectors exist only on the output-capable pins
  localparam logic [7:0] PPM_P2_FUNC_MASK = 8'h9e;
  localparam logic [7:0] PPM_ALL_MASK = 8'hff;
  localparam logic [7:0] PPM_NONE = 8'h00;

  // ----------------------------------------
  // Pin positions
  // ----------------------------------------
  localparam int PPM_P1_A_CNT = 0;
  localparam int PPM_P1_A_DIR = 1;
  localparam int PPM_P1_A_CLR = 2;
  localparam int PPM_P1_B_CNT = 3;
  localparam int PPM_P1_B_DIR = 4;
  localparam int PPM_P1_B_CLR = 5;
  localparam int PPM_P2_C_IN = 0;
  localparam int PPM_P2_C_CLR = 5;
  localparam int PPM_P2_D_IN = 6;
  localparam int PPM_P2_D_OUT = 7;

  // ----------------------------------------
  // Single-bit write format
  // ----------------------------------------
  localparam int PPM_BITOP_FLAG = 31;
  localparam int PPM_BITOP_POS = 8;
  localparam logic [31:0] PPM_RD_ZERO = 32'h00000000;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ppm_apb_req_t;

  // APB answer from this slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppm_apb_rsp_t;

  // Inputs handed to the timer unit
  typedef struct packed {
    logic a_count;
    logic a_dir;
    logic a_clear;
    logic b_count;
    logic b_dir;
    logic b_clear;
    logic c_in;
    logic c_clear;
    logic d_in;
    logic d_clear;
  } ppm_timer_in_t;

  // Outputs coming from the timer unit
  typedef struct packed {
    logic a_out;
    logic b_out;
    logic [3:0] c_out;
    logic d_out;
  } ppm_timer_out_t;

  // Byte address of a register index
  function automatic logic [31:0] ppm_addr(input logic [31:0] idx);
    ppm_addr = {idx[29:0], 2'b00};
  endfunction

endpackage

// ---- core/ppm_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module ppm_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // ----------------------------------------
  // Two flip-flop stages
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- core/ppm_port_ctrl.sv ----
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module ppm_port_ctrl
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire ppm_pkg::ppm_apb_req_t apb_req,
  output ppm_pkg::ppm_apb_rsp_t apb_rsp,
  // Port 1 pins
  input wire logic [5:0] p1_pin_in,
  output logic [5:0] p1_pin_out,
  output logic [5:0] p1_pin_oe_n,
  // Port 2 pins
  input wire logic [7:0] p2_pin_in,
  output logic [7:0] p2_pin_out,
  output logic [7:0] p2_pin_oe_n,
  // Timer unit
  input wire ppm_pkg::ppm_timer_out_t timer_out,
  output ppm_pkg::ppm_timer_in_t timer_in,
  // External interrupt requests
  output logic [3:0] p1_ext_irq,
  output logic [7:0] p2_ext_irq
);

  import ppm_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // All registers of the block in one word
  typedef struct packed {
    logic [7:0] p1_data;
    logic [7:0] p1_dir;
    logic [7:0] p1_mode;
    logic [7:0] p1_func;
    logic [7:0] p2_data;
    logic [7:0] p2_dir;
    logic [7:0] p2_mode;
    logic [7:0] p2_func;
    logic [5:0] p1_out;
    logic [5:0] p1_oe_n;
    logic [7:0] p2_out;
    logic [7:0] p2_oe_n;
    ppm_timer_in_t tin;
    logic [3:0] p1_irq;
    logic [7:0] p2_irq;
    ppm_apb_rsp_t rsp;
  } ppm_state_t;

  ppm_state_t st;
  ppm_state_t next_st;
  // Synchronised pin levels
  logic [5:0] p1_lvl;
  logic [7:0] p2_lvl;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  ppm_sync #(.WIDTH(6)) u_sync_p1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(p1_pin_in),
    .sync_out(p1_lvl)
  );

  ppm_sync #(.WIDTH(8)) u_sync_p2 (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(p2_pin_in),
    .sync_out(p2_lvl)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte or single-bit write, then fixed bits applied
  function automatic logic [7:0] wr_reg(
    input logic [7:0] old,
    input ppm_apb_req_t req,
    input logic [7:0] keep,
    input logic [7:0] ones
  );
    logic [7:0] v;
    logic [2:0] pos;
    v = old;
    pos = req.pwdata[PPM_BITOP_POS +: 3];
    if (req.pwdata[PPM_BITOP_FLAG])
    begin
      // Single bit: position and value in the data word
      v[pos] = req.pwdata[0];
    end
    else if (req.pstrb[0])
    begin
      // Whole byte in lane 0
      v = req.pwdata[7:0];
    end
    wr_reg = (v & keep) | ones;
  endfunction

  // Data read: latch for outputs, pin for inputs
  function automatic logic [7:0] rd_data(
    input logic [7:0] latch,
    input logic [7:0] lvl,
    input logic [7:0] in_sel
  );
    rd_data = (latch & ~in_sel) | (lvl & in_sel);
  endfunction

  // Bus request fields
  logic acc;
  logic wr_go;
  logic [31:0] a;
  // Pins currently sensed as inputs
  logic [7:0] p1_in_sel;
  logic [7:0] p2_in_sel;
  // Effective timer output selection per pin
  logic p1_a_out;
  logic p1_b_out;
  logic [7:0] p2_alt_out;
  logic [7:0] p2_alt_val;
  logic [7:0] p1_lvl8;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    a = apb_req.paddr;
    // Access phase: psel and penable both high
    acc = apb_req.psel && apb_req.penable;
    // Write lands on the edge that sees pready
    wr_go = acc && st.rsp.pready && apb_req.pwrite;
    p1_lvl8 = {2'b00, p1_lvl};

    // Control mode, output function chosen
    // selector gated by mode bit
    // function bit0 picks timer a output
    p1_a_out = st.p1_mode[PPM_P1_A_CNT] && st.p1_func[PPM_P1_A_CNT];
    // function bit3 picks timer b output
    p1_b_out = st.p1_mode[PPM_P1_B_CNT] && st.p1_func[PPM_P1_B_CNT];
    // port2 output-capable pins in control mode
    p2_alt_out = st.p2_mode & PPM_P2_FUNC_MASK;
    p2_alt_val = {timer_out.d_out, 2'b00, timer_out.c_out, 1'b0};

    p1_in_sel = (st.p1_dir & ~st.p1_mode) |
      (st.p1_mode & ~{4'b0000, p1_b_out, 2'b00, p1_a_out});
    p2_in_sel = (st.p2_dir & ~st.p2_mode) | (st.p2_mode & ~p2_alt_out);

    // Port 1 pin drive
    // direction 0 enables the buffer in port mode
    // latch drives the pin in port mode
    next_st.p1_out = st.p1_data[5:0];
    next_st.p1_oe_n = p1_in_sel[5:0];
    if (p1_a_out)
    begin
      next_st.p1_out[PPM_P1_A_CNT] = timer_out.a_out;
    end
    if (p1_b_out)
    begin
      next_st.p1_out[PPM_P1_B_CNT] = timer_out.b_out;
    end

    // Port 2 pin drive
    // port2 own direction and mode
    next_st.p2_out = (st.p2_data & ~p2_alt_out) | (p2_alt_val & p2_alt_out);
    next_st.p2_oe_n = p2_in_sel;

    // Timer inputs, zero unless the pin is routed
    // count inputs in control input mode
    next_st.tin.a_count = st.p1_mode[PPM_P1_A_CNT] && !p1_a_out &&
      p1_lvl[PPM_P1_A_CNT];
    next_st.tin.b_count = st.p1_mode[PPM_P1_B_CNT] && !p1_b_out &&
      p1_lvl[PPM_P1_B_CNT];
    next_st.tin.a_dir = st.p1_mode[PPM_P1_A_DIR] && p1_lvl[PPM_P1_A_DIR];
    next_st.tin.b_dir = st.p1_mode[PPM_P1_B_DIR] && p1_lvl[PPM_P1_B_DIR];
    next_st.tin.a_clear = st.p1_mode[PPM_P1_A_CLR] && p1_lvl[PPM_P1_A_CLR];
    next_st.tin.b_clear = st.p1_mode[PPM_P1_B_CLR] && p1_lvl[PPM_P1_B_CLR];
    next_st.tin.c_in = st.p2_mode[PPM_P2_C_IN] && p2_lvl[PPM_P2_C_IN];
    next_st.tin.c_clear = st.p2_mode[PPM_P2_C_CLR] && p2_lvl[PPM_P2_C_CLR];
    next_st.tin.d_in = st.p2_mode[PPM_P2_D_IN] && p2_lvl[PPM_P2_D_IN];
    next_st.tin.d_clear = next_st.tin.d_in;

    // Interrupt request inputs, pin level in control mode
    // pins 1, 2, 4 and 5 as interrupt inputs
    next_st.p1_irq = {
      st.p1_mode[PPM_P1_B_CLR] && p1_lvl[PPM_P1_B_CLR],
      st.p1_mode[PPM_P1_B_DIR] && p1_lvl[PPM_P1_B_DIR],
      st.p1_mode[PPM_P1_A_CLR] && p1_lvl[PPM_P1_A_CLR],
      st.p1_mode[PPM_P1_A_DIR] && p1_lvl[PPM_P1_A_DIR]
    };
    // every port2 pin carries an interrupt
    next_st.p2_irq = st.p2_mode & p2_lvl;

    // APB answer: one wait state, then pready
    next_st.rsp.pready = acc && !st.rsp.pready;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata = PPM_RD_ZERO;
    if (acc && !st.rsp.pready)
    begin
      // Address decode for the answer
      if (a == ppm_addr(PPM_P1_DATA_IDX))
      begin
        next_st.rsp.prdata[7:0] =
          rd_data(st.p1_data, p1_lvl8, p1_in_sel) & PPM_P1_PIN_MASK;
      end
      else if (a == ppm_addr(PPM_P2_DATA_IDX))
      begin
        next_st.rsp.prdata[7:0] = rd_data(st.p2_data, p2_lvl, p2_in_sel);
      end
      else if (a == ppm_addr(PPM_P1_DIR_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p1_dir;
      end
      else if (a == ppm_addr(PPM_P2_DIR_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p2_dir;
      end
      else if (a == ppm_addr(PPM_P1_MODE_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p1_mode;
      end
      else if (a == ppm_addr(PPM_P2_MODE_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p2_mode;
      end
      else if (a == ppm_addr(PPM_P1_FUNC_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p1_func;
      end
      else if (a == ppm_addr(PPM_P2_FUNC_IDX))
      begin
        next_st.rsp.prdata[7:0] = st.p2_func;
      end
      else
      begin
        // Unmapped address
        next_st.rsp.pslverr = 1'b1;
      end
    end

    // Register writes
    // byte or single-bit writes
    if (wr_go)
    begin
      if (a == ppm_addr(PPM_P1_DATA_IDX))
      begin
        next_st.p1_data = wr_reg(st.p1_data, apb_req, PPM_P1_PIN_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P2_DATA_IDX))
      begin
        next_st.p2_data = wr_reg(st.p2_data, apb_req, PPM_ALL_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P1_DIR_IDX))
      begin
        next_st.p1_dir = wr_reg(st.p1_dir, apb_req, PPM_P1_PIN_MASK,
          PPM_P1_DIR_ONES);
      end
      else if (a == ppm_addr(PPM_P2_DIR_IDX))
      begin
        next_st.p2_dir = wr_reg(st.p2_dir, apb_req, PPM_ALL_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P1_MODE_IDX))
      begin
        next_st.p1_mode = wr_reg(st.p1_mode, apb_req, PPM_P1_PIN_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P2_MODE_IDX))
      begin
        next_st.p2_mode = wr_reg(st.p2_mode, apb_req, PPM_ALL_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P1_FUNC_IDX))
      begin
        // only bits 0 and 3 kept
        next_st.p1_func = wr_reg(st.p1_func, apb_req, PPM_P1_FUNC_MASK,
          PPM_NONE);
      end
      else if (a == ppm_addr(PPM_P2_FUNC_IDX))
      begin
        next_st.p2_func = wr_reg(st.p2_func, apb_req, PPM_P2_FUNC_MASK,
          PPM_NONE);
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.p1_data <= PPM_DATA_RST;
      st.p2_data <= PPM_DATA_RST;
      st.p1_dir <= PPM_DIR_RST;
      st.p2_dir <= PPM_DIR_RST;
      st.p1_mode <= PPM_MODE_RST;
      st.p2_mode <= PPM_MODE_RST;
      st.p1_func <= PPM_FUNC_RST;
      st.p2_func <= PPM_FUNC_RST;
      // Buffers off while in reset
      st.p1_oe_n <= PPM_DIR_RST[5:0];
      st.p2_oe_n <= PPM_DIR_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------
  assign apb_rsp = st.rsp;
  assign p1_pin_out = st.p1_out;
  assign p1_pin_oe_n = st.p1_oe_n;
  assign p2_pin_out = st.p2_out;
  assign p2_pin_oe_n = st.p2_oe_n;
  assign timer_in = st.tin;
  assign p1_ext_irq = st.p1_irq;
  assign p2_ext_irq = st.p2_irq;

endmodule

// ---- test/ppm_port_ctrl_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port and bus checker
// ----------------------------------------
module ppm_port_ctrl_monitor
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus
  input wire ppm_pkg::ppm_apb_req_t apb_req,
  input wire ppm_pkg::ppm_apb_rsp_t apb_rsp,
  // Pins
  input wire logic [5:0] p1_pin_in,
  input wire logic [5:0] p1_pin_out,
  input wire logic [5:0] p1_pin_oe_n,
  input wire logic [7:0] p2_pin_in,
  input wire logic [7:0] p2_pin_out,
  input wire logic [7:0] p2_pin_oe_n,
  // Timer and interrupts
  input wire ppm_pkg::ppm_timer_out_t timer_out,
  input wire ppm_pkg::ppm_timer_in_t timer_in,
  input wire logic [3:0] p1_ext_irq,
  input wire logic [7:0] p2_ext_irq
);
  // One clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_wait;
    apb_req.psel && apb_req.penable && !$past(apb_req.penable)
      |=> apb_rsp.pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("ready not one cycle after access");
  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_inacc;
    apb_rsp.pready |-> apb_req.psel && apb_req.penable;
  endproperty
  a_inacc: assert property (p_inacc)
    else $error("ready outside access phase");
  property p_err;
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_rst;
    $fell(reset) |-> p1_pin_oe_n == 6'h3f && p2_pin_oe_n == 8'hff;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pins not inputs after reset");
  property p_clr_b;
    p1_ext_irq[3] || timer_in.b_clear |-> $past(p1_pin_in[5], 3);
  endproperty
  a_clr_b: assert property (p_clr_b)
    else $error("pin5 request without level");
  property p_clr_a;
    p1_ext_irq[1] || timer_in.a_clear |-> $past(p1_pin_in[2], 3);
  endproperty
  a_clr_a: assert property (p_clr_a)
    else $error("pin2 request without level");
  property p_dir;
    !$past(p1_pin_in[1], 3) |-> !timer_in.a_dir && !p1_ext_irq[0];
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin1 request without level");
  property p_irq2;
    (p2_ext_irq & ~$past(p2_pin_in, 3)) == 8'h00;
  endproperty
  a_irq2: assert property (p_irq2)
    else $error("port2 request without level");
endmodule

bind ppm_port_ctrl ppm_port_ctrl_monitor i_ppm_port_ctrl_monitor (
  .ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out),
  .p1_pin_oe_n(p1_pin_oe_n), .p2_pin_in(p2_pin_in),
  .p2_pin_out(p2_pin_out), .p2_pin_oe_n(p2_pin_oe_n),
  .timer_out(timer_out), .timer_in(timer_in),
  .p1_ext_irq(p1_ext_irq), .p2_ext_irq(p2_ext_irq)
);

// ---- test/ppm_port_ctrl_test.sv ----
`timescale 1ns/1ps
module ppm_port_ctrl_test;
  import ppm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  ppm_apb_req_t req = '0;
  ppm_apb_rsp_t rsp;
  logic [5:0] p1_in = 6'h00, p1_out, p1_oe;
  logic [7:0] p2_in = 8'h00, p2_out, p2_oe, irq2;
  logic [3:0] irq1;
  ppm_timer_out_t tout = '0;
  ppm_timer_in_t tin;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  ppm_port_ctrl i_ppm_port_ctrl (
    .ref_clk(ref_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe_n(p1_oe),
    .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe),
    .timer_out(tout), .timer_in(tin), .p1_ext_irq(irq1),
    .p2_ext_irq(irq2)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    $display("mismatches %0d compares %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled
  task apb(input logic w, input logic [31:0] idx, input logic [31:0] d,
           input logic [3:0] st);
    @(posedge ref_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= {idx[29:0], 2'b00};
    req.pwdata <= d;
    req.pstrb <= st;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // Wait for ready; only the hang guard ends a lost answer
    do
    begin
      @(posedge ref_clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [31:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask

  // Read and compare, no error expected
  task rdchk(input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000, 4'hf);
    chk(rd, exp);
    chk(er, 1'b0);
  endtask

  // Let edges pass, then settle
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rdchk(PPM_P1_DIR_IDX, 32'h000000ff);
    rdchk(PPM_P1_MODE_IDX, 32'h00000000);
    rdchk(PPM_P1_FUNC_IDX, 32'h00000000);
    chk(p1_oe, 6'h3f);
  endtask

  task t_fixed;
    // Software keeps the fixed bits at their stated values
    wr(PPM_P1_DIR_IDX, 32'h000000c0);
    rdchk(PPM_P1_DIR_IDX, 32'h000000c0);
    wr(PPM_P1_MODE_IDX, 32'h0000003f);
    rdchk(PPM_P1_MODE_IDX, 32'h0000003f);
    wr(PPM_P1_FUNC_IDX, 32'h00000009);
    rdchk(PPM_P1_FUNC_IDX, 32'h00000009);
    wr(PPM_P1_MODE_IDX, 32'h00000000);
    wr(PPM_P1_FUNC_IDX, 32'h00000000);
    // Byte lane off: write dropped
    apb(1'b1, PPM_P1_DIR_IDX, 32'h000000ff, 4'h0);
    rdchk(PPM_P1_DIR_IDX, 32'h000000c0);
    // Single-bit write sets bit 5 only
    apb(1'b1, PPM_P1_DIR_IDX, 32'h80000501, 4'h0);
    rdchk(PPM_P1_DIR_IDX, 32'h000000e0);
    // Unmapped place answers with error
    apb(1'b0, 32'h00000000, 32'h00000000, 4'hf);
    chk(er, 1'b1);
    chk(rd, 32'h00000000);
    // Port 1 latch drives outputs, pin 5 input reads its level
    wr(PPM_P1_DATA_IDX, 32'h0000003f);
    cyc(2);
    chk(p1_out, 6'h3f);
    rdchk(PPM_P1_DATA_IDX, 32'h0000001f);
  endtask

  task t_port2;
    wr(PPM_P2_DIR_IDX, 32'h0000000f);
    wr(PPM_P2_DATA_IDX, 32'h000000a5);
    cyc(2);
    chk(p2_oe, 8'h0f);
    chk(p2_out[7:4], 4'ha);
    @(posedge ref_clk);
    p2_in <= 8'h3c;
    cyc(4);
    rdchk(PPM_P2_DATA_IDX, 32'h000000ac);
  endtask

  task t_p1ctrl;
    logic [5:0] v [2];
    v = '{6'h2d, 6'h12};
    wr(PPM_P1_DIR_IDX, 32'h000000c0);
    wr(PPM_P1_MODE_IDX, 32'h0000003f);
    foreach (v[i])
    begin
      @(posedge ref_clk);
      p1_in <= v[i];
      cyc(4);
      chk(p1_oe, 6'h3f);
      chk({tin.b_clear, tin.b_dir, tin.b_count, tin.a_clear, tin.a_dir,
           tin.a_count}, v[i]);
      chk(irq1, {v[i][5], v[i][4], v[i][2], v[i][1]});
    end
    @(posedge ref_clk);
    tout.a_out <= 1'b1;
    tout.b_out <= 1'b0;
    wr(PPM_P1_FUNC_IDX, 32'h00000009);
    cyc(2);
    chk(p1_oe, 6'h36);
    chk({p1_out[3], p1_out[0]}, 2'b01);
    // Port mode again: selectors ignored
    wr(PPM_P1_MODE_IDX, 32'h00000000);
    cyc(2);
    chk(p1_oe, 6'h00);
    chk(p1_out, 6'h3f);
    // Port mode pins raise no request that would need masking
    chk(irq1, 4'h0);
  endtask

  task t_p2ctrl;
    wr(PPM_P2_DIR_IDX, 32'h000000ff);
    wr(PPM_P2_MODE_IDX, 32'h000000ff);
    @(posedge ref_clk);
    tout.c_out <= 4'ha;
    tout.d_out <= 1'b1;
    p2_in <= 8'h61;
    cyc(4);
    chk(p2_oe, 8'h61);
    chk({p2_out[7], p2_out[4:1]}, 5'h1a);
    chk({tin.c_in, tin.c_clear, tin.d_in, tin.d_clear}, 4'hf);
    chk(irq2, 8'h61);
    wr(PPM_P2_MODE_IDX, 32'h00000000);
    cyc(2);
    chk(p2_oe, 8'hff);
  endtask

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(1);
    t_reset;
    t_fixed;
    t_port2;
    t_p1ctrl;
    t_p2ctrl;
    stop_test;
  end
endmodule
